// ===== dv/irh_drv_model.sv
// Purpose: guest side of the buffer stream, collecting every word
// Assumes: words are kept in arrival order in got
// Notes:   slow mode stalls every other cycle to stretch transfers
`default_nettype none
module irh_drv_model (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // buffer words
  input  wire logic        out_valid,
  input  wire logic [31:0] out_data,
  input  wire logic        slow,
  input  wire logic        out_last,
  input  wire logic        out_event,
  output logic             out_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] got[$];
  logic [1:0]  fl[$];
  logic        ph;
  // ready moves off the sampling edge so no race with the design
  always @(negedge clk_sys) begin
    ph        <= rst ? 1'b0 : ~ph;
    out_ready <= !slow || ph;
  end
  // whole area taken in order, walked by the bench
  always @(posedge clk_sys) begin
    if (out_valid && out_ready) begin
      got.push_back(out_data);
      fl.push_back({out_event, out_last});
    end
  end
endmodule
`default_nettype wire

// ===== dv/irh_handler_tb.sv
// Purpose: self-checking bench of the request handler
// Assumes: one domain; inputs change on the falling edge
// Notes:   unmap status comes from a queue model of the mappings
`default_nettype none
module irh_handler_tb;
  import irh_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 0, rst = 1, ce = 1, slow = 0, req_valid = 0, req_probe = 0, req_dom_known = 1;
  logic req_ep_known = 1, probe_offered = 1, map_valid = 0, cfg_wr = 0, flt_valid = 0;
  logic flt_attached = 0, flt_internal = 0, flt_addr_ok = 0, evb_avail = 1, drop_when_full = 0;
  logic req_ready, resp_valid, out_valid, out_ready, out_last, out_event, map_done, map_ok;
  logic cfg_ok, cfg_err, flt_ready, evb_take, ev_drop;
  logic [7:0]  cfg_sub = 0, resp_status;
  logic [15:0] evb_bytes = 0, resp_used;
  logic [31:0] req_dom = 0, req_pad = 0, req_ep = 0, map_dom = 0, map_ep = 0, cfg_ep = 0;
  logic [31:0] flt_ep = 0, out_data, seed = 32'h7582, ep;
  logic [63:0] req_vs = 0, req_ve = 0, map_vs = 0, map_ve = 0, cfg_start = 0, cfg_end = 0;
  logic [63:0] flt_addr = 0, rs, re, ms[$], me[$], xw[$];
  int          num_errors = 0, samples_checked = 0, n;
  always #5 clk_sys = ~clk_sys;
  irh_handler u_dut (.*);
  irh_drv_model u_drv (.*);
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // unmap model: a split refuses before anything is removed
  function automatic logic [7:0] um(logic k, logic [31:0] p, logic [63:0] s, e);
    if (!k) return S_NOENT;
    if (p != 0) return S_INVAL;
    foreach (ms[i]) if (!(me[i] < s || e < ms[i]) && (ms[i] < s || me[i] > e)) return S_RANGE;
    for (int i = ms.size() - 1; i >= 0; i--) if (ms[i] >= s && me[i] <= e) begin
      ms.delete(i);
      me.delete(i);
    end
    return S_OK;
  endfunction
  task automatic chk(input string nm, input logic [63:0] g, input logic [63:0] x);
    samples_checked++;
    if (g !== x) begin
      $display("mismatch %s expected %h seen %h", nm, x, g);
      num_errors++;
    end
  endtask
  task automatic finish_test();
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic tmo(input int k);
    if (k >= 300) begin
      num_errors++;
      finish_test();
    end
  endtask
  // bounded wait on a design output, polled at falling edges
  task automatic wt(ref logic s);
    for (n = 0; n < 300 && s !== 1'b1; n++) @(negedge clk_sys);
    tmo(n);
  endtask
  task automatic rq(input logic p, k, input logic [31:0] pd, input logic [63:0] s, e,
                    input logic [7:0] xp, input logic [15:0] xu);
    logic [7:0] x;
    x = p ? xp : um(k, pd, s, e);
    // let an edge pass so the strobe is never set twice in one step
    @(negedge clk_sys);
    u_drv.got.delete();
    u_drv.fl.delete();
    {req_probe, req_dom_known, req_ep_known, req_pad, req_vs, req_ve} = {p, k, k, pd, s, e};
    req_valid = 1;
    wt(req_ready);
    @(negedge clk_sys);
    req_valid = 0;
    wt(resp_valid);
    chk("status", resp_status, x);
    chk("used", resp_used, xu);
  endtask
  task automatic mp(input logic [63:0] s, e, input logic x);
    @(negedge clk_sys);
    {map_vs, map_ve, map_valid} = {s, e, 1'b1};
    @(negedge clk_sys);
    map_valid = 0;
    chk("map_ok", {map_done, map_ok}, {1'b1, x});
    if (x) ms.push_back(s);
    if (x) me.push_back(e);
  endtask
  task automatic cf(input logic [7:0] sb, input logic [63:0] s, e, input logic x);
    @(negedge clk_sys);
    {cfg_sub, cfg_start, cfg_end, cfg_wr} = {sb, s, e, 1'b1};
    @(negedge clk_sys);
    cfg_wr = 0;
    chk("cfg", {cfg_ok, cfg_err}, {x, !x});
  endtask
  // fault report; short format when the buffer cannot hold the long one
  task automatic ft(input int k, input logic [15:0] b, input logic av);
    int w;
    w = b >= EVT_LONG_BYTES ? 6 : 4;
    @(negedge clk_sys);
    {evb_bytes, evb_avail, drop_when_full} = {b, av, !av};
    {flt_internal, flt_attached, flt_addr_ok} = {k == 0, k == 2, k != 0};
    {flt_ep, flt_addr} = {xs(), xs(), xs()};
    u_drv.got.delete();
    u_drv.fl.delete();
    flt_valid = 1;
    wt(flt_ready);
    @(negedge clk_sys);
    flt_valid = 0;
    if (!av) begin
      wt(ev_drop);
      repeat (3) @(negedge clk_sys);
      chk("drop", u_drv.got.size(), 0);
    end else begin
      wt(evb_take);
      for (n = 0; n < 300 && u_drv.got.size() < w; n++) @(negedge clk_sys);
      tmo(n);
      repeat (3) @(negedge clk_sys);
      chk("size", u_drv.got.size(), w);
      chk("reason", u_drv.got[0], k);
      chk("flags", u_drv.got[1], k == 2);
      if (k == 2) chk("addr", {u_drv.got[5], u_drv.got[4]}, flt_addr);
      chk("evtag", {u_drv.fl[0], u_drv.fl[w-1]}, 4'b1011);
      chk("ep", u_drv.got[2], flt_ep);
      chk("pad", u_drv.got[3], 0);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    ep = xs();
    rs = {32'h0, xs() & 32'h0FFF_F000 | 32'h0000_1000};
    re = rs + 64'hFFF;
    repeat (20) @(negedge clk_sys);
    rst = 0;
    mp(0, 4, 1);
    mp(5, 9, 1);
    mp(10, 19, 1);
    rq(0, 0, 0, 0, 4, 0, 16'h4);
    rq(0, 1, 32'h0000_0100, 0, 4, 0, 16'h4);
    rq(0, 1, 0, 0, 14, 0, 16'h4);
    rq(0, 1, 0, 0, 4, 0, 16'h4);
    rq(0, 1, 0, 5, 25, 0, 16'h4);
    rq(0, 1, 0, 0, 14, 0, 16'h4);
    {req_ep, cfg_ep, map_ep, probe_offered} = {ep, ep, ep, 1'b0};
    rq(1, 1, 0, 0, 0, S_OK, 16'h0);
    chk("quiet", u_drv.got.size(), 0);
    probe_offered = 1;
    rq(1, 0, 0, 0, 0, S_NOENT, 16'h4);
    cf(SUB_MSI, rs, re, 1);
    slow = 1;
    rq(1, 1, 0, 0, 0, S_OK, 16'h0044);
    chk("ptag", {u_drv.fl[0], u_drv.fl[15]}, 4'b0001);
    xw = {64'h0014_0001, 64'h1, rs[31:0], rs[63:32], re[31:0], re[63:32]};
    repeat (10) xw.push_back(0);
    foreach (xw[i]) chk("word", u_drv.got[i], xw[i]);
    chk("words", u_drv.got.size(), 16);
    cf(SUB_RESERVED, rs + 1, rs + 2, 0);
    cf(SUB_MSI, rs + 64'h2000, rs + 64'h2FFF, 0);
    mp(rs + 64'h800, rs + 64'h900, 0);
    {cfg_ep, req_ep} = {~ep, ~ep};
    for (int i = 0; i < 3; i++) cf(0, 64'h1_0000_0000 + i * 64'h1000, 64'h1_0000_00FF + i * 64'h1000, 1);
    rq(1, 1, 0, 0, 0, S_INVAL, 16'h4);
    chk("none", u_drv.got.size(), 0);
    for (int k = 0; k < 3; k++) ft(k, k == 1 ? EVT_SHORT_BYTES : EVT_LONG_BYTES, 1);
    ft(0, EVT_LONG_BYTES, 0);
    finish_test();
  end
endmodule
`default_nettype wire

// ===== src/irh_handler.sv
// Purpose: unmap, probe and fault-report handling of an I/O translation unit
// Assumes: attach logic flags known domains and endpoints with each request
// Notes:   one buffer stream, shared by probe data and event reports
`default_nettype none

module irh_handler
  import irh_pkg::*;
(
  // clock and reset
  input  wire logic             clk_sys,
  input  wire logic             rst,
  input  wire logic             ce,
  // request in
  input  wire logic             req_valid,
  output logic                  req_ready,
  input  wire logic             req_probe,
  input  wire logic [DOM_W-1:0] req_dom,
  input  wire logic             req_dom_known,
  input  wire logic [VA_W-1:0]  req_vs,
  input  wire logic [VA_W-1:0]  req_ve,
  input  wire logic [31:0]      req_pad,
  input  wire logic [EP_W-1:0]  req_ep,
  input  wire logic             req_ep_known,
  input  wire logic             probe_offered,
  // response out
  output logic                  resp_valid,
  output logic [7:0]            resp_status,
  output logic [15:0]           resp_used,
  // buffer words out
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [31:0]           out_data,
  output logic                  out_last,
  output logic                  out_event,
  // mapping insert
  input  wire logic             map_valid,
  input  wire logic [DOM_W-1:0] map_dom,
  input  wire logic [EP_W-1:0]  map_ep,
  input  wire logic [VA_W-1:0]  map_vs,
  input  wire logic [VA_W-1:0]  map_ve,
  output logic                  map_done,
  output logic                  map_ok,
  // reserved region loading
  input  wire logic             cfg_wr,
  input  wire logic [EP_W-1:0]  cfg_ep,
  input  wire logic [7:0]       cfg_sub,
  input  wire logic [VA_W-1:0]  cfg_start,
  input  wire logic [VA_W-1:0]  cfg_end,
  output logic                  cfg_ok,
  output logic                  cfg_err,
  // translation fault in
  input  wire logic             flt_valid,
  output logic                  flt_ready,
  input  wire logic [EP_W-1:0]  flt_ep,
  input  wire logic             flt_attached,
  input  wire logic             flt_internal,
  input  wire logic [VA_W-1:0]  flt_addr,
  input  wire logic             flt_addr_ok,
  // event buffers
  input  wire logic             evb_avail,
  input  wire logic [15:0]      evb_bytes,
  input  wire logic             drop_when_full,
  output logic                  evb_take,
  output logic                  ev_drop
);
  irh_resv_if rv ();

  irh_state_type     st;
  logic [MAP_N-1:0]  mv;
  logic [DOM_W-1:0]  mdom [MAP_N];
  logic [VA_W-1:0]   mvs  [MAP_N];
  logic [VA_W-1:0]   mve  [MAP_N];
  logic [RESV_N-1:0] m_q;
  logic [2:0]        sub_q;
  logic [4:0]        cnt_q;
  logic [4:0]        nwords_q;
  logic              pend;
  logic [EP_W-1:0]   p_ep;
  logic [7:0]        p_reason;
  logic [VA_W-1:0]   p_addr;
  logic              p_aflag;
  logic              short_q;

  ////////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic [1:0] low_idx(input logic [RESV_N-1:0] m);
    logic [1:0] r;
    r = '0;
    for (int i = RESV_N - 1; i >= 0; i--) begin
      if (m[i]) begin
        r = 2'(i);
      end
    end
    return r;
  endfunction

  function automatic int ones(input logic [RESV_N-1:0] m);
    int n;
    n = 0;
    for (int i = 0; i < RESV_N; i++) begin
      n += int'(m[i]);
    end
    return n;
  endfunction

  irh_resv_table u_resv (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .ce        (ce),
    .cfg_wr    (cfg_wr),
    .cfg_ep    (cfg_ep),
    .cfg_sub   (cfg_sub),
    .cfg_start (cfg_start),
    .cfg_end   (cfg_end),
    .cfg_ok    (cfg_ok),
    .cfg_err   (cfg_err),
    .rv        (rv.store)
  );

  ////////////////////////////////////////////////////////////////////////////
  // unmap range decode over the mapping store
  logic [MAP_N-1:0] hit;
  logic [MAP_N-1:0] cov;
  logic             split;
  for (genvar g = 0; g < MAP_N; g++) begin : g_map
    assign hit[g] = mv[g] && mdom[g] == req_dom &&
                    irh_overlap(mvs[g], mve[g], req_vs, req_ve);
    assign cov[g] = mvs[g] >= req_vs && mve[g] <= req_ve;
  end
  assign split = |(hit & ~cov);

  // request acceptance and unmap verdict
  logic       fire;
  logic       um_fire;
  logic       pr_fire;
  logic [7:0] um_status;
  logic       fits;
  logic       pr_go;
  assign req_ready = ce && st == ST_IDLE;
  assign fire      = req_valid && req_ready;
  assign um_fire   = fire && !req_probe;
  assign pr_fire   = fire && req_probe;
  // padding is refused without removal, the simpler of the two permitted answers
  assign um_status = !req_dom_known ? S_NOENT :
                     req_pad != '0  ? S_INVAL :
                     split          ? S_RANGE :
                                      S_OK;
  logic [MAP_N-1:0] rm;
  assign rm = (um_fire && um_status == S_OK) ? hit : '0;

  // probe verdict; endpoint padding never reaches this logic
  assign rv.pr_ep = req_ep;
  assign fits     = ones(rv.pr_mask) * int'(PROP_WORDS) <= int'(PROBE_WORDS);
  assign pr_go    = pr_fire && probe_offered && req_ep_known && fits;

  // map insert into the lowest free entry
  logic [MAP_N-1:0] free_pick;
  logic             map_good;
  logic [MAP_N-1:0] set_m;
  assign rv.map_ep  = map_ep;
  assign rv.map_vs  = map_vs;
  assign rv.map_ve  = map_ve;
  assign free_pick  = ~mv & (mv + 1'b1);
  assign map_good   = !rv.map_hit && free_pick != '0 && map_ve >= map_vs;
  assign set_m      = (ce && map_valid && map_good) ? free_pick : '0;

  ////////////////////////////////////////////////////////////////////////////
  // event start decision while idle and no request is waiting
  logic ev_try;
  logic ev_go;
  logic ev_lose;
  assign ev_try  = st == ST_IDLE && pend && !req_valid;
  assign ev_go   = ev_try && evb_avail && evb_bytes >= EVT_SHORT_BYTES;
  // a buffer too small for either format loses the report, never split it
  assign ev_lose = ev_try && !ev_go && (evb_avail || drop_when_full);

  // word generator; one output register, loaded while it is empty or the consumer's ready is high
  logic [1:0]  cur;
  logic        out_load;
  logic        done;
  logic [31:0] prop_w;
  logic [31:0] evt_w;
  logic [31:0] next_word;
  assign cur      = low_idx(m_q);
  assign out_load = st != ST_IDLE && cnt_q < nwords_q && (!out_valid || out_ready);
  assign done     = st != ST_IDLE && cnt_q == nwords_q && (!out_valid || out_ready);
  assign out_last = out_valid && cnt_q == nwords_q;

  // property words: header, subtype, start, end
  always_comb begin
    unique case (sub_q)
      3'h0:    prop_w = {PROP_LEN, PROP_TYPE_RESV};
      3'h1:    prop_w = {24'h00_0000, rv.slot_sub[cur]};
      3'h2:    prop_w = rv.slot_start[cur][31:0];
      3'h3:    prop_w = rv.slot_start[cur][63:32];
      3'h4:    prop_w = rv.slot_end[cur][31:0];
      default: prop_w = rv.slot_end[cur][63:32];
    endcase
  end

  // report words; short format carries no address
  always_comb begin
    unique case (cnt_q)
      5'h00:   evt_w = {24'h00_0000, p_reason};
      5'h01:   evt_w = (p_aflag && !short_q) ? FLT_F_ADDRESS : 32'h0000_0000;
      5'h02:   evt_w = p_ep;
      5'h04:   evt_w = p_addr[31:0];
      5'h05:   evt_w = p_addr[63:32];
      default: evt_w = 32'h0000_0000;
    endcase
  end

  assign next_word  = st == ST_EVENT ? evt_w :
                      m_q != '0      ? prop_w : 32'h0000_0000;
  assign rv.adv_set = (st == ST_PROBE && out_load && m_q != '0 && sub_q == PROP_WORDS - 3'h1)
                      ? (RESV_N'(1) << cur) : '0;

  ////////////////////////////////////////////////////////////////////////////
  // mapping store
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      mv <= '0;
      for (int i = 0; i < MAP_N; i++) begin
        mdom[i] <= '0;
        mvs[i]  <= '0;
        mve[i]  <= '0;
      end
    end else if (ce) begin
      mv <= (mv & ~rm) | set_m;
      for (int i = 0; i < MAP_N; i++) begin
        if (set_m[i]) begin
          mdom[i] <= map_dom;
          mvs[i]  <= map_vs;
          mve[i]  <= map_ve;
        end
      end
    end
  end

  // map answer pulse
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      map_done <= 1'b0;
      map_ok   <= 1'b0;
    end else if (ce) begin
      map_done <= map_valid;
      map_ok   <= map_valid && map_good;
    end
  end

  // pending fault record; capture only while empty, so no set/clear clash
  assign flt_ready = ce && !pend;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pend     <= 1'b0;
      p_ep     <= '0;
      p_reason <= REASON_UNKNOWN;
      p_addr   <= '0;
      p_aflag  <= 1'b0;
    end else if (ce) begin
      if (flt_valid && !pend) begin
        pend     <= 1'b1;
        p_ep     <= flt_ep;
        p_reason <= flt_internal  ? REASON_UNKNOWN :
                    !flt_attached ? REASON_DOMAIN  : REASON_MAPPING;
        p_addr   <= flt_addr;
        p_aflag  <= flt_addr_ok;
      end else if (ev_go || ev_lose) begin
        pend <= 1'b0;
      end
    end
  end

  // request answers and buffer pulses
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      resp_valid  <= 1'b0;
      resp_status <= S_OK;
      resp_used   <= '0;
      evb_take    <= 1'b0;
      ev_drop     <= 1'b0;
    end else if (ce) begin
      resp_valid <= (fire && !pr_go) || (done && st == ST_PROBE);
      evb_take   <= ev_go;
      ev_drop    <= ev_lose;
      if (um_fire) begin
        resp_status <= um_status;
        resp_used   <= TAIL_BYTES;
      end else if (pr_fire && !probe_offered) begin
        resp_status <= S_OK;
        resp_used   <= '0;
      end else if (pr_fire && !pr_go) begin
        resp_status <= !req_ep_known ? S_NOENT : S_INVAL;
        resp_used   <= TAIL_BYTES;
      end else if (done && st == ST_PROBE) begin
        resp_status <= S_OK;
        resp_used   <= PROBE_SIZE + TAIL_BYTES;
      end
    end
  end

  // transfer sequencer
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st        <= ST_IDLE;
      m_q       <= '0;
      sub_q     <= '0;
      cnt_q     <= '0;
      nwords_q  <= '0;
      short_q   <= 1'b0;
      out_valid <= 1'b0;
      out_data  <= '0;
      out_event <= 1'b0;
    end else if (ce) begin
      unique case (st)
        ST_IDLE: begin
          cnt_q <= '0;
          sub_q <= '0;
          if (pr_go) begin
            st        <= ST_PROBE;
            m_q       <= rv.pr_mask;
            nwords_q  <= PROBE_WORDS;
            out_event <= 1'b0;
          end else if (ev_go) begin
            st        <= ST_EVENT;
            short_q   <= evb_bytes < EVT_LONG_BYTES;
            nwords_q  <= evb_bytes < EVT_LONG_BYTES ? EVT_SHORT_WORDS : EVT_LONG_WORDS;
            out_event <= 1'b1;
          end
        end
        ST_PROBE, ST_EVENT: begin
          if (out_load) begin
            out_valid <= 1'b1;
            out_data  <= next_word;
            cnt_q     <= cnt_q + 5'h01;
            if (st == ST_PROBE && m_q != '0) begin
              sub_q <= sub_q == PROP_WORDS - 3'h1 ? 3'h0 : sub_q + 3'h1;
              if (sub_q == PROP_WORDS - 3'h1) begin
                m_q <= m_q & (m_q - 1'b1);
              end
            end
          end else if (done) begin
            out_valid <= 1'b0;
            st        <= ST_IDLE;
          end
        end
        default: st <= ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  a_unmap_pad_inval: assert property (ce && um_fire && req_dom_known && req_pad != '0 |=>
    resp_valid && resp_status == S_INVAL) else $error("padding not refused");
  a_unmap_noent: assert property (ce && um_fire && !req_dom_known |=>
    resp_valid && resp_status == S_NOENT) else $error("unknown domain accepted");
  a_split_keeps: assert property (ce && um_fire && req_dom_known && req_pad == '0 && split &&
    !map_valid |=> resp_status == S_RANGE && mv == $past(mv)) else $error("split altered store");
  a_unmap_removes: assert property (ce && um_fire && um_status == S_OK |=>
    (mv & $past(hit)) == '0 && resp_status == S_OK) else $error("mapping left behind");
  a_probe_off_zero: assert property (ce && pr_fire && !probe_offered |=>
    resp_valid && resp_used == '0 && st == ST_IDLE && !out_valid) else $error("unoffered probe wrote");
  a_probe_big_inval: assert property (ce && pr_fire && probe_offered && req_ep_known && !fits |=>
    resp_status == S_INVAL && !out_valid) else $error("oversized list written");
  a_prop_header: assert property (ce && out_load && st == ST_PROBE && m_q != '0 && sub_q == 3'h0 |=>
    out_data == {PROP_LEN, PROP_TYPE_RESV}) else $error("bad property header");
  a_fill_zero: assert property (ce && out_load && st == ST_PROBE && m_q == '0 |=>
    out_data == 32'h0000_0000) else $error("tail not zeroed");
  a_reason_domain: assert property (ce && flt_valid && flt_ready && !flt_internal &&
    !flt_attached |=> pend && p_reason == REASON_DOMAIN) else $error("wrong reason");
  a_evt_pad_zero: assert property (ce && out_load && st == ST_EVENT && cnt_q == 5'h03 |=>
    out_data == 32'h0000_0000) else $error("report padding set");
  a_short_no_addr: assert property (ce && out_load && st == ST_EVENT && short_q &&
    cnt_q == 5'h01 |=> out_data == 32'h0000_0000) else $error("short report flags address");
  a_map_resv_refuse: assert property (ce && map_valid && rv.map_hit |=>
    map_done && !map_ok) else $error("reserved overlap mapped");

  c_probe_done: cover property (ce && done && st == ST_PROBE);
  c_unmap_ok: cover property (ce && um_fire && um_status == S_OK && hit != '0);
  c_event_sent: cover property (ce && done && st == ST_EVENT);
  c_event_drop: cover property (ce && ev_lose);
endmodule

`default_nettype wire

// ===== src/irh_pkg.sv
// Purpose: shared constants, types and helpers of the request handler
// Assumes: little-endian 32-bit words on the buffer stream
// Notes:   status codes and sizes are plain defaults where nothing fixes them
`default_nettype none

package irh_pkg;
  localparam int EP_W   = 32;
  localparam int DOM_W  = 32;
  localparam int VA_W   = 64;
  localparam int MAP_N  = 8;
  localparam int RESV_N = 4;

  // request status codes
  localparam logic [7:0] S_OK    = 8'h00;
  localparam logic [7:0] S_INVAL = 8'h04;
  localparam logic [7:0] S_RANGE = 8'h05;
  localparam logic [7:0] S_NOENT = 8'h06;

  // probe buffer layout
  localparam logic [15:0] PROBE_SIZE     = 16'h0040;
  localparam logic [15:0] TAIL_BYTES     = 16'h0004;
  localparam logic [4:0]  PROBE_WORDS    = 5'(PROBE_SIZE / 16'h0004);
  localparam logic [15:0] PROP_TYPE_RESV = 16'h0001;
  localparam logic [15:0] PROP_LEN       = 16'h0014;
  localparam logic [2:0]  PROP_WORDS     = 3'h6;
  localparam logic [7:0]  SUB_RESERVED   = 8'h00;
  localparam logic [7:0]  SUB_MSI        = 8'h01;

  // fault report layout
  localparam logic [7:0]  REASON_UNKNOWN  = 8'h00;
  localparam logic [7:0]  REASON_DOMAIN   = 8'h01;
  localparam logic [7:0]  REASON_MAPPING  = 8'h02;
  localparam logic [31:0] FLT_F_ADDRESS   = 32'h0000_0001;
  localparam logic [15:0] EVT_LONG_BYTES  = 16'h0018;
  localparam logic [15:0] EVT_SHORT_BYTES = 16'h0010;
  localparam logic [4:0]  EVT_LONG_WORDS  = 5'h06;
  localparam logic [4:0]  EVT_SHORT_WORDS = 5'h04;

  typedef enum logic [1:0] {ST_IDLE, ST_PROBE, ST_EVENT} irh_state_type;

  // inclusive ranges share at least one address
  function automatic logic irh_overlap(input logic [VA_W-1:0] as, input logic [VA_W-1:0] ae,
                                       input logic [VA_W-1:0] bs, input logic [VA_W-1:0] be);
    return !(ae < bs || be < as);
  endfunction
endpackage

`default_nettype wire

// ===== src/irh_resv_if.sv
// Purpose: carrier between the handler and its reserved-region store
// Assumes: one clock, driven by the two modules only
// Notes:   slot arrays are read by the probe word generator
`default_nettype none

interface irh_resv_if;
  import irh_pkg::*;
  logic [EP_W-1:0]   map_ep;
  logic [VA_W-1:0]   map_vs;
  logic [VA_W-1:0]   map_ve;
  logic              map_hit;
  logic [EP_W-1:0]   pr_ep;
  logic [RESV_N-1:0] pr_mask;
  logic [RESV_N-1:0] adv_set;
  logic [7:0]        slot_sub   [RESV_N];
  logic [VA_W-1:0]   slot_start [RESV_N];
  logic [VA_W-1:0]   slot_end   [RESV_N];

  modport store (input map_ep, map_vs, map_ve, pr_ep, adv_set,
                 output map_hit, pr_mask, slot_sub, slot_start, slot_end);
  modport user  (output map_ep, map_vs, map_ve, pr_ep, adv_set,
                 input map_hit, pr_mask, slot_sub, slot_start, slot_end);
endinterface

`default_nettype wire

// ===== src/irh_resv_table.sv
// Purpose: reserved-region slots per endpoint, with overlap lookups
// Assumes: regions are loaded by platform logic before probing
// Notes:   a slot only blocks maps once it has been advertised
`default_nettype none

module irh_resv_table
  import irh_pkg::*;
(
  // clock and reset
  input  wire logic            clk_sys,
  input  wire logic            rst,
  input  wire logic            ce,
  // region loading
  input  wire logic            cfg_wr,
  input  wire logic [EP_W-1:0] cfg_ep,
  input  wire logic [7:0]      cfg_sub,
  input  wire logic [VA_W-1:0] cfg_start,
  input  wire logic [VA_W-1:0] cfg_end,
  output logic                 cfg_ok,
  output logic                 cfg_err,
  // lookups
  irh_resv_if.store            rv
);
  logic [RESV_N-1:0] valid;
  logic [RESV_N-1:0] adv;
  logic [EP_W-1:0]   ep [RESV_N];
  logic [RESV_N-1:0] clash;
  logic [RESV_N-1:0] msi_dup;
  logic [RESV_N-1:0] map_hits;
  logic [RESV_N-1:0] free_pick;
  logic              load_ok;

  ////////////////////////////////////////////////////////////////////////////
  // per-slot comparisons
  for (genvar g = 0; g < RESV_N; g++) begin : g_slot
    assign clash[g]    = valid[g] && ep[g] == cfg_ep &&
                         irh_overlap(rv.slot_start[g], rv.slot_end[g], cfg_start, cfg_end);
    assign msi_dup[g]  = valid[g] && ep[g] == cfg_ep && rv.slot_sub[g] == SUB_MSI &&
                         cfg_sub == SUB_MSI;
    assign map_hits[g] = valid[g] && adv[g] && ep[g] == rv.map_ep &&
                         irh_overlap(rv.slot_start[g], rv.slot_end[g], rv.map_vs, rv.map_ve);
    assign rv.pr_mask[g] = valid[g] && ep[g] == rv.pr_ep;
  end

  // regions overlapping one of the same endpoint, or a second doorbell region of one endpoint, never enter the store
  assign free_pick  = ~valid & (valid + 1'b1);
  assign load_ok    = cfg_wr && free_pick != '0 && clash == '0 && msi_dup == '0 &&
                      cfg_end >= cfg_start;
  assign rv.map_hit = |map_hits;

  ////////////////////////////////////////////////////////////////////////////
  // slot storage
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      valid   <= '0;
      adv     <= '0;
      cfg_ok  <= 1'b0;
      cfg_err <= 1'b0;
      for (int i = 0; i < RESV_N; i++) begin
        ep[i]            <= '0;
        rv.slot_sub[i]   <= '0;
        rv.slot_start[i] <= '0;
        rv.slot_end[i]   <= '0;
      end
    end else if (ce) begin
      cfg_ok  <= load_ok;
      cfg_err <= cfg_wr && !load_ok;
      valid   <= valid | (load_ok ? free_pick : '0);
      adv     <= adv | (rv.adv_set & valid);
      for (int i = 0; i < RESV_N; i++) begin
        if (load_ok && free_pick[i]) begin
          ep[i]            <= cfg_ep;
          rv.slot_sub[i]   <= cfg_sub;
          rv.slot_start[i] <= cfg_start;
          rv.slot_end[i]   <= cfg_end;
        end
      end
    end
  end
endmodule

`default_nettype wire
